// ===== common/lsg_regs.vh
// Field positions, reset values and sequence constants of the gain control
`ifndef LSG_REGS_VH
`define LSG_REGS_VH

// ****************************************************************
// Word widths
// ****************************************************************
`define LSG_WORD_W        16
`define LSG_MANT_W        6
`define LSG_NUM_W         9
`define LSG_PIN_W         4

// ****************************************************************
// Configuration word layout
// ****************************************************************
`define LSG_CFG_BAND_BIT  1
`define LSG_CFG_MANT_LO   2
`define LSG_CFG_MANT_HI   7

// ****************************************************************
// Reset values
// ****************************************************************
`define LSG_CFG_RESET     16'h00FE
`define LSG_IMG_RESET     16'h0000

// ****************************************************************
// Pin bundle positions in the synchroniser
// ****************************************************************
`define LSG_PIN_CLK       0
`define LSG_PIN_GATE      1
`define LSG_PIN_STROBE    2
`define LSG_PIN_SIN       3

// ****************************************************************
// Mode-switch sequence and gain decode factors
// ****************************************************************
`define LSG_GATE_PATTERN  3'b101
`define LSG_SEQ_IDLE      3'd0
`define LSG_SEQ_EDGE3     3'd3
`define LSG_SEQ_EDGE4     3'd4
`define LSG_GAIN_ONE      9'h001
`define LSG_BAND_HIGH     9'h003
`define LSG_MANT_BASE     9'h020

`endif

// ===== dv/led_sink_gain_mode_control_tb_top.sv
// Self-checking bench of the gain mode control
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin error_cnt++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module led_sink_gain_mode_control_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        rdy = 1'b0;
  logic [15:0] lw = 16'h0000;
  wire         pc, gn, st, sd, so, gm, bs, iv, ia;
  wire  [15:0] sink, idat;
  wire  [5:0]  mant;
  wire  [8:0]  num;
  int          error_cnt = 0;
  int          compares = 0;
  // Config word, then band, mantissa and gain numerator
  logic [31:0] rows [7] = '{{16'h0000, 1'h0, 6'h00, 9'h020},
    {16'hFF01, 1'h0, 6'h00, 9'h020}, {16'h0002, 1'h1, 6'h00, 9'h060},
    {16'h0004, 1'h0, 6'h20, 9'h040}, {16'h0080, 1'h0, 6'h01, 9'h021},
    {16'h00FE, 1'h1, 6'h3F, 9'h11D}, {16'h0056, 1'h1, 6'h2A, 9'h0DE}};

  always #25 clk = ~clk;

  lsg_ctrl_model u_ctl (.i_sys_clk(clk), .o_pin_clk(pc), .o_gate_n(gn),
    .o_strobe(st), .o_sin(sd));
  lsg_gain_mode_ctrl dut (.i_sys_clk(clk), .i_rst(rst), .i_pin_clk(pc),
    .i_output_gate_n(gn), .i_latch_strobe(st), .i_serial_in(sd),
    .o_serial_out(so), .o_sink_outputs(sink), .o_gain_mode(gm),
    .o_band_select(bs), .o_gain_mantissa(mant), .o_gain_num(num),
    .o_img_valid(iv), .i_img_ready(rdy), .o_img_data(idat),
    .o_img_accept(ia));

  task automatic stop_test();
  begin
    $display("errors=%0d compares=%0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  end
  endtask

  task automatic load(input logic [15:0] w);
  begin
    u_ctl.word(w);
    lw = w;
    repeat (2) @(negedge clk);
  end
  endtask

  task automatic mode(input logic [4:0] s, input logic [15:0] img);
  begin
    for (int i = 0; i < 5; i++)
    begin
      u_ctl.tick(i != 1, s[i], i[0]);
      if (i == 1) `CHK(sink, img)
    end
    repeat (2) @(negedge clk);
  end
  endtask

  initial
  begin
    #400000;
    error_cnt++;
    stop_test();
  end

  initial
  begin
    repeat (5) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    repeat (3) @(negedge clk);
    `CHK({gm, bs, mant, num, iv}, {1'b0, 1'b1, 6'h3F, 9'h11D, 1'b0})
    load(16'hA5C3);
    `CHK({sink, iv, idat}, {16'hA5C3, 1'b1, 16'hA5C3})
    mode(5'b11000, 16'hA5C3);
    `CHK(so, lw[10])
    `CHK(gm, 1'b1)
    `CHK(ia, 1'b1)
    foreach (rows[i])
    begin
      load(rows[i][31:16]);
      `CHK({bs, mant, num}, rows[i][15:0])
      `CHK({gm, sink, so}, {1'b1, 16'hA5C3, lw[15]})
    end
    mode(5'b10000, 16'hA5C3);
    `CHK(gm, 1'b0)
    load(16'h3C5A);
    `CHK({ia, iv, idat}, {1'b0, 1'b1, 16'hA5C3})
    load(16'h0F0F);
    `CHK(sink, 16'h0F0F)
    `CHK({bs, mant, num}, rows[6][15:0])
    rdy = 1'b1;
    @(negedge clk);
    `CHK(idat, 16'h3C5A)
    @(negedge clk);
    `CHK({iv, ia}, 2'b01)
    mode(5'b01000, 16'h0F0F);
    `CHK(gm, 1'b1)
    rst = 1'b1;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
    `CHK({gm, bs, mant, num, iv}, {1'b0, 1'b1, 6'h3F, 9'h11D, 1'b0})
    stop_test();
  end
endmodule // led_sink_gain_mode_control_tb_top

// ===== dv/lsg_ctrl_model.sv
// Controller model driving shift clock, gate, strobe and data pins
module lsg_ctrl_model (
  input  wire  i_sys_clk,
  output logic o_pin_clk,
  output logic o_gate_n,
  output logic o_strobe,
  output logic o_sin
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle levels of the pulled-up gate and pulled-down strobe
  initial
  begin
    o_pin_clk = 1'b0;
    o_gate_n = 1'b1;
    o_strobe = 1'b0;
    o_sin = 1'b0;
  end

  task automatic tick(input logic g, input logic s, input logic d);
  begin
    @(negedge i_sys_clk);
    {o_gate_n, o_strobe, o_sin} = {g, s, d};
    repeat (5) @(negedge i_sys_clk);
    o_pin_clk = 1'b1;
    repeat (5) @(negedge i_sys_clk);
    o_pin_clk = 1'b0;
    o_sin = ~d;
  end
  endtask

  task automatic word(input logic [15:0] w);
  begin
    for (int i = 15; i >= 0; i--)
      tick(1'b0, 1'b0, w[i]);
    repeat (6) @(negedge i_sys_clk);
    o_strobe = 1'b1;
    repeat (6) @(negedge i_sys_clk);
    o_strobe = 1'b0;
    repeat (6) @(negedge i_sys_clk);
  end
  endtask
endmodule // lsg_ctrl_model

// ===== dv/lsg_gain_mode_ctrl_checker.sv
// Port checker of the gain mode control
`include "lsg_regs.vh"
module lsg_gain_mode_ctrl_checker (
  input wire                   i_sys_clk,
  input wire                   i_rst,
  input wire                   i_pin_clk,
  input wire                   i_output_gate_n,
  input wire                   i_latch_strobe,
  input wire                   i_img_ready,
  input wire                   o_serial_out,
  input wire [`LSG_WORD_W-1:0] o_sink_outputs,
  input wire                   o_gain_mode,
  input wire                   o_band_select,
  input wire [`LSG_MANT_W-1:0] o_gain_mantissa,
  input wire [`LSG_NUM_W-1:0]  o_gain_num,
  input wire                   o_img_valid,
  input wire [`LSG_WORD_W-1:0] o_img_data,
  input wire                   o_img_accept
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);
  wire [8:0] exp_num = (o_band_select ? 9'h003 : 9'h001)
    * (9'h020 + {3'h0, o_gain_mantissa});

  a_reset_values: assert property ($fell(i_rst) |-> !o_gain_mode &&
    o_band_select && o_gain_mantissa == 6'h3F && !o_img_valid)
    else $error("reset values wrong");
  a_gain_product: assert property (!$past(i_rst) |->
    o_gain_num == $past(exp_num)) else $error("gain product wrong");
  a_gate_blank: assert property (i_output_gate_n [*8] |->
    o_sink_outputs == 16'h0000) else $error("outputs on while gated");
  a_shift_hold: assert property ($stable(i_pin_clk) [*8] |=>
    $stable(o_serial_out)) else $error("serial out moved");
  a_mode_hold: assert property ($stable(i_pin_clk) [*8] |=>
    $stable(o_gain_mode)) else $error("mode moved without edge");
  a_cfg_hold: assert property (!i_latch_strobe [*8] |=>
    $stable(o_gain_num)) else $error("gain moved without strobe");
  a_stall_hold: assert property (o_img_valid && !i_img_ready |=>
    o_img_valid && $stable(o_img_data)) else $error("stalled word lost");
  a_full_flag: assert property (!o_img_accept |-> o_img_valid)
    else $error("full without data");
  a_gain_no_push: assert property (o_gain_mode |=>
    !$rose(o_img_valid)) else $error("image queued in gain mode");

  c_gain_entry: cover property ($rose(o_gain_mode));
  c_buf_full: cover property (!o_img_accept);
  c_stall: cover property (o_img_valid && !i_img_ready);
endmodule // lsg_gain_mode_ctrl_checker

bind lsg_gain_mode_ctrl lsg_gain_mode_ctrl_checker u_chk (.i_sys_clk,
  .i_rst, .i_pin_clk, .i_output_gate_n, .i_latch_strobe, .i_img_ready,
  .o_serial_out, .o_sink_outputs, .o_gain_mode, .o_band_select,
  .o_gain_mantissa, .o_gain_num, .o_img_valid, .o_img_data,
  .o_img_accept);

// ===== hw/lsg_gain_mode_ctrl.v
// Mode detection, shift path and gain latch of the LED sink driver
// Function
// - Gate pattern high-low-high on pin clock edges starts a mode switch.
// - Strobe sampled at fourth edge: high selects gain setup, else normal.
// - Strobe latches nothing between third and fifth edges of the switch.
// - Gate low pulse of the switch still enables the sink outputs.
// - Serial data keeps shifting through during a mode switch.
// - Levels count only at pin clock rising edges; don't-cares ignored.
// - Normal mode after power-on until a switch selects gain setup.
// - Gain mode strobe loads configuration latch; normal loads output latch.
// - Configuration latch holds gain until reset or rewritten.
// - Word bit 1 is band, bits 2..7 mantissa bits 0..5.
// - Gain is (1+2*band)/3 times (1+D/32)/3, mantissa bit 0 weight 32.
// - Band zero selects low band, one the high band.
// - Gain code resets to all ones, gain 0.9896.
`include "lsg_regs.vh"

module lsg_gain_mode_ctrl (
  input  wire                    i_sys_clk,
  input  wire                    i_rst,
  input  wire                    i_pin_clk,
  input  wire                    i_output_gate_n,
  input  wire                    i_latch_strobe,
  input  wire                    i_serial_in,
  output reg                     o_serial_out,
  output reg  [`LSG_WORD_W-1:0]  o_sink_outputs,
  output reg                     o_gain_mode,
  output wire                    o_band_select,
  output wire [`LSG_MANT_W-1:0]  o_gain_mantissa,
  output reg  [`LSG_NUM_W-1:0]   o_gain_num,
  output wire                    o_img_valid,
  input  wire                    i_img_ready,
  output wire [`LSG_WORD_W-1:0]  o_img_data,
  output wire                    o_img_accept
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  reg  [`LSG_PIN_W-1:0]   sync1;
  reg  [`LSG_PIN_W-1:0]   sync2;
  reg  [`LSG_PIN_W-1:0]   sync3;
  reg  [`LSG_PIN_W-1:0]   pin_lvl;
  wire [`LSG_PIN_W-1:0]   next_pin_lvl;
  wire                    clk_rise;
  wire                    strobe_rise;
  wire                    gate_smp;
  wire                    strobe_smp;
  wire                    sin_smp;

  // Follow stages two and three once they agree, else hold
  assign next_pin_lvl = (sync2 & sync3) | (pin_lvl & (sync2 | sync3));

  always @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      sync1   <= 4'h0;
      sync2   <= 4'h0;
      sync3   <= 4'h0;
      pin_lvl <= 4'h0;
    end
    else
    begin
      sync1   <= {i_serial_in, i_latch_strobe, i_output_gate_n, i_pin_clk};
      sync2   <= sync1;
      sync3   <= sync2;
      pin_lvl <= next_pin_lvl;
    end
  end

  assign clk_rise    = next_pin_lvl[`LSG_PIN_CLK] & ~pin_lvl[`LSG_PIN_CLK];
  assign strobe_rise = next_pin_lvl[`LSG_PIN_STROBE]
                     & ~pin_lvl[`LSG_PIN_STROBE];
  assign gate_smp    = next_pin_lvl[`LSG_PIN_GATE];
  assign strobe_smp  = next_pin_lvl[`LSG_PIN_STROBE];
  assign sin_smp     = next_pin_lvl[`LSG_PIN_SIN];

  // ****************************************************************
  // Shift register
  // ****************************************************************
  reg [`LSG_WORD_W-1:0] shift_reg;

  always @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      shift_reg    <= 16'h0000;
      o_serial_out <= 1'b0;
    end
    else if (clk_rise)
    begin
      shift_reg    <= {shift_reg[`LSG_WORD_W-2:0], sin_smp};
      o_serial_out <= shift_reg[`LSG_WORD_W-2];
    end
  end

  // ****************************************************************
  // Mode-switch sequence detector
  // ****************************************************************
  reg [2:0] gate_hist;
  reg [2:0] seq_pos;
  reg       mode_pick;
  wire [2:0] next_gate_hist;
  wire       seq_start;
  wire       seq_window;

  assign next_gate_hist = {gate_hist[1:0], gate_smp};
  assign seq_start  = clk_rise & (seq_pos == `LSG_SEQ_IDLE)
                    & (next_gate_hist == `LSG_GATE_PATTERN);
  assign seq_window = (seq_pos != `LSG_SEQ_IDLE) | seq_start;

  always @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      gate_hist   <= 3'b000;
      seq_pos     <= `LSG_SEQ_IDLE;
      mode_pick   <= 1'b0;
      o_gain_mode <= 1'b0;
    end
    else if (clk_rise)
    begin
      gate_hist <= next_gate_hist;
      case (seq_pos)
        `LSG_SEQ_IDLE:
        begin
          if (seq_start)
            seq_pos <= `LSG_SEQ_EDGE3;
        end
        `LSG_SEQ_EDGE3:
        begin
          mode_pick <= strobe_smp;
          seq_pos   <= `LSG_SEQ_EDGE4;
        end
        `LSG_SEQ_EDGE4:
        begin
          o_gain_mode <= mode_pick;
          seq_pos     <= `LSG_SEQ_IDLE;
        end
        default:
        begin
          seq_pos <= `LSG_SEQ_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Latches
  // ****************************************************************
  reg  [`LSG_WORD_W-1:0] img_latch;
  reg  [`LSG_WORD_W-1:0] gain_config_latch;
  wire                   latch_evt;
  wire                   buf_ready;

  assign latch_evt = strobe_rise & ~seq_window;

  always @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      img_latch         <= `LSG_IMG_RESET;
      gain_config_latch <= `LSG_CFG_RESET;
    end
    else if (latch_evt)
    begin
      if (o_gain_mode)
        gain_config_latch <= shift_reg;
      else
        img_latch <= shift_reg;
    end
  end

  always @(posedge i_sys_clk)
  begin
    if (i_rst)
      o_sink_outputs <= 16'h0000;
    else if (pin_lvl[`LSG_PIN_GATE])
      o_sink_outputs <= 16'h0000;
    else
      o_sink_outputs <= img_latch;
  end

  // ****************************************************************
  // Gain decode
  // ****************************************************************
  wire [`LSG_NUM_W-1:0] band_fac;
  wire [`LSG_NUM_W-1:0] mant_fac;
  wire [17:0]           gain_prod;
  wire [`LSG_MANT_W-1:0] mant_val;
  genvar k;

  // mantissa bit 0 is the heaviest
  generate
    for (k = 0; k < `LSG_MANT_W; k = k + 1)
    begin : g_mant
      assign mant_val[`LSG_MANT_W-1-k] =
        gain_config_latch[`LSG_CFG_MANT_LO+k];
    end
  endgenerate

  assign o_gain_mantissa = mant_val;
  assign o_band_select   = gain_config_latch[`LSG_CFG_BAND_BIT];
  assign band_fac = o_band_select ? `LSG_BAND_HIGH : `LSG_GAIN_ONE;
  assign mant_fac = `LSG_MANT_BASE + {3'b000, mant_val};
  assign gain_prod = band_fac * mant_fac;

  always @(posedge i_sys_clk)
  begin
    if (i_rst)
      o_gain_num <= 9'h000;
    else
      o_gain_num <= gain_prod[`LSG_NUM_W-1:0];
  end

  // ****************************************************************
  // Image word stream
  // ****************************************************************
  assign o_img_accept = buf_ready;

  lsg_pair_buf #(
    .WIDTH (`LSG_WORD_W)
  ) u_img_buf (
    .i_sys_clk   (i_sys_clk),
    .i_rst       (i_rst),
    .i_in_valid  (latch_evt & ~o_gain_mode),
    .o_in_ready  (buf_ready),
    .i_in_data   (shift_reg),
    .o_out_valid (o_img_valid),
    .i_out_ready (i_img_ready),
    .o_out_data  (o_img_data)
  );

endmodule // lsg_gain_mode_ctrl

// ===== hw/lsg_pair_buf.v
// Two-entry buffer with valid and ready on both sides
module lsg_pair_buf #(
  parameter WIDTH = 16
) (
  input  wire             i_sys_clk,
  input  wire             i_rst,
  input  wire             i_in_valid,
  output wire             o_in_ready,
  input  wire [WIDTH-1:0] i_in_data,
  output wire             o_out_valid,
  input  wire             i_out_ready,
  output wire [WIDTH-1:0] o_out_data
);

  reg [WIDTH-1:0] slot0;
  reg [WIDTH-1:0] slot1;
  reg [1:0]       fill;
  wire            push;
  wire            pop;

  assign o_in_ready  = (fill != 2'd2);
  assign o_out_valid = (fill != 2'd0);
  assign o_out_data  = slot0;
  assign push        = i_in_valid & o_in_ready;
  assign pop         = o_out_valid & i_out_ready;

  always @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      slot0 <= {WIDTH{1'b0}};
      slot1 <= {WIDTH{1'b0}};
      fill  <= 2'd0;
    end
    else
    begin
      case ({push, pop})
        2'b10:
        begin
          if (fill == 2'd0)
            slot0 <= i_in_data;
          else
            slot1 <= i_in_data;
          fill <= fill + 2'd1;
        end
        2'b01:
        begin
          slot0 <= slot1;
          fill  <= fill - 2'd1;
        end
        2'b11:
        begin
          if (fill == 2'd1)
            slot0 <= i_in_data;
          else
          begin
            slot0 <= slot1;
            slot1 <= i_in_data;
          end
        end
        default:
        begin
          fill <= fill;
        end
      endcase
    end
  end

endmodule // lsg_pair_buf
